/* logic/vpc_loader.sv */
// Power-up option loader with system fail control and AXI4-Lite registers.
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Auto slot strap latched at power-up reset release.
// - Hold bit initialised by strap, writable.
// - Auto slot mode sets hold during system reset.
// - System fail asserted while hold is set.
// - Auto-clear option clears hold by itself.
// - Auto clear occurs 1 ms after reset.
// - Geo strap zero clears enable and base.
// - Geo strap one sets enable, inverted GA.
// - System reset reloads enable and base.
// - Both straps: geo, auto if GA all high.
// - Output enable initialised by strap, writable.
// - Fail output from board fail and enable.
// - Board fail from pin or software bit.
// - Clear bit disables, set bit enables output.
// - Syscon straps fix function on or off.
// - Both syscon straps high select automatic.
// - Automatic: grant3 low enables syscon.
// - Options sampled at power-up reset release.
module vpc_loader
  import vpc_pkg::*;
#(
  parameter int AUTOCLR_CYCLES = AUTOCLR_CYC
) (
  // Clock and reset.
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  // Backplane and strap inputs.
  input  wire logic        POWERUP_RESET_N_I,
  input  wire logic        SYSTEM_RESET_N_I,
  input  wire logic [3:0]  OPTION_DATA_I,
  input  wire logic [4:0]  GEO_ADDR_N_I,
  input  wire logic        GRANT3_DAISY_N_I,
  input  wire logic        SYSCON_FORCE_ON_N_I,
  input  wire logic        SYSCON_FORCE_OFF_N_I,
  input  wire logic        BOARD_FAIL_N_I,
  // Derived outputs.
  output logic             SYSTEM_FAIL_O,
  output logic             SYSCON_FUNCTION_O,
  output logic             CFG_SPACE_EN_O,
  output logic [4:0]       CFG_BASE_O,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  // ==========================================================================
  // Option latch.
  logic [3:0]  opt;
  logic [4:0]  ga_latched;
  logic        syscon;
  logic        pur_q;
  logic        pur_qq;
  logic        srst_act_q;
  logic        hold;
  logic        sfen;
  logic        board_fail_bit;
  logic        cfg_en;
  logic [4:0]  cfg_base;
  logic [CNT_W-1:0] clr_cnt;
  logic        clr_run;
  vpc_mode_t   mode;
  logic        pur_rise;
  logic        srst_active;
  logic        srst_end;

  // Power-up reset release is its rising edge; system reset level is active low.
  // Power-up reset counts as system reset until one cycle after the new options
  // are latched, so the reload sees the fresh straps rather than the old ones.
  assign pur_rise    = POWERUP_RESET_N_I && !pur_q;
  assign srst_active = !SYSTEM_RESET_N_I || !pur_qq;
  assign srst_end    = !srst_active && srst_act_q;

  // Edge history of both reset inputs.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pur_q      <= 1'b0;
      pur_qq     <= 1'b0;
      srst_act_q <= 1'b1;
    end else begin
      pur_q      <= POWERUP_RESET_N_I;
      pur_qq     <= pur_q;
      srst_act_q <= srst_active;
    end
  end

  // Straps captured once at the power-up reset release and kept until the next.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      opt        <= 4'h0;
      ga_latched <= 5'h00;
      syscon     <= 1'b0;
    end else if (pur_rise) begin
      opt        <= OPTION_DATA_I;
      ga_latched <= GEO_ADDR_N_I;
      if (!SYSCON_FORCE_ON_N_I && SYSCON_FORCE_OFF_N_I) begin
        syscon <= 1'b1;
      end else if (SYSCON_FORCE_ON_N_I && !SYSCON_FORCE_OFF_N_I) begin
        syscon <= 1'b0;
      end else if (SYSCON_FORCE_ON_N_I && SYSCON_FORCE_OFF_N_I) begin
        syscon <= !GRANT3_DAISY_N_I;
      end else begin
        syscon <= 1'b0;
      end
    end
  end

  // Addressing mode derived from latched options and geographic address.
  always_comb begin
    mode = VPC_CFG_OFF;
    case ({opt[OPT_AUTO_SLOT], opt[OPT_GEO_SLOT]})
      2'h1:    mode = VPC_CFG_GEO;
      2'h2:    mode = VPC_CFG_AUTO;
      2'h3:    mode = (ga_latched == GA_ALL_HIGH) ? VPC_CFG_AUTO : VPC_CFG_GEO;
      default: mode = VPC_CFG_OFF;
    endcase
  end

  // ==========================================================================
  // Bus slave.
  logic        aw_hold;
  logic        w_hold;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        wr_ok;
  logic        lane0;

  // Decodes whether an address hits a mapped register.
  function automatic logic vpc_mapped(input logic [7:0] a);
    vpc_mapped = ((a & ADDR_MASK) == a) && (a <= ADDR_OPTIONS);
  endfunction

  assign wr_fire = aw_hold && w_hold && !S_AXI_BVALID;
  assign wr_ok   = wr_fire && vpc_mapped(aw_addr);
  assign lane0   = w_strb[0];

  // Address and data are taken independently and held until the response.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_hold       <= 1'b0;
      w_hold        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_hold       <= 1'b1;
        aw_addr       <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_hold       <= 1'b1;
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= vpc_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Read channel answers one cycle after the address is taken.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= vpc_mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      S_AXI_RDATA   <= 32'h0000_0000;
      case (S_AXI_ARADDR)
        ADDR_BUS_CONTROL:   S_AXI_RDATA[BIT_HOLD] <= hold;
        ADDR_CTRL_STATUS:   S_AXI_RDATA[BIT_SFEN] <= sfen;
        ADDR_BUS_STATUS: begin
          S_AXI_RDATA[BIT_BOARD_FAIL_BIT]  <= board_fail_bit;
          S_AXI_RDATA[BIT_SYSCON] <= syscon;
          S_AXI_RDATA[BIT_SFO]    <= SYSTEM_FAIL_O;
        end
        ADDR_BIT_CLEAR:     S_AXI_RDATA[BIT_CLRSET] <= sfen;
        ADDR_BIT_SET:       S_AXI_RDATA[BIT_CLRSET] <= sfen;
        ADDR_CFG_ATTRIBUTE: S_AXI_RDATA[BIT_CFG_EN] <= cfg_en;
        ADDR_CFG_BASE:      S_AXI_RDATA[BASE_MSB:BASE_LSB] <= cfg_base;
        ADDR_OPTIONS:       S_AXI_RDATA[OPT_GEO_SLOT:OPT_SFEN_RV] <= opt;
        default:            S_AXI_RDATA <= 32'h0000_0000;
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end

  // ==========================================================================
  // Control bits.

  // Auto-clear counter starts when system reset ends in auto slot mode with the auto-clear option set.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clr_run <= 1'b0;
      clr_cnt <= '0;
    end else if (srst_active) begin
      clr_run <= 1'b0;
      clr_cnt <= '0;
    end else if (srst_end && mode == VPC_CFG_AUTO && opt[OPT_AUTOCLR]) begin
      clr_run <= 1'b1;
      clr_cnt <= '0;
    end else if (clr_run) begin
      if (clr_cnt == CNT_W'(AUTOCLR_CYCLES - 1)) begin
        clr_run <= 1'b0;
      end
      clr_cnt <= clr_cnt + 1'b1;
    end
  end

  // Hold bit: set by system reset in auto slot mode, auto or software cleared.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold <= 1'b0;
    end else if (srst_active) begin
      hold <= (mode == VPC_CFG_AUTO);
    end else if (clr_run && clr_cnt == CNT_W'(AUTOCLR_CYCLES - 1)) begin
      hold <= 1'b0;
    end else if (wr_ok && aw_addr == ADDR_BUS_CONTROL && lane0) begin
      hold <= w_data[BIT_HOLD];
    end
  end

  // Output enable: strap value on reset, software control otherwise.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sfen <= 1'b0;
    end else if (srst_active) begin
      sfen <= opt[OPT_SFEN_RV];
    end else if (wr_ok && aw_addr == ADDR_CTRL_STATUS && lane0) begin
      sfen <= w_data[BIT_SFEN];
    end else if (wr_ok && aw_addr == ADDR_BIT_CLEAR && lane0 && w_data[BIT_CLRSET]) begin
      sfen <= 1'b0;
    end else if (wr_ok && aw_addr == ADDR_BIT_SET && lane0 && w_data[BIT_CLRSET]) begin
      sfen <= 1'b1;
    end
  end

  // Software board fail bit.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      board_fail_bit <= 1'b0;
    end else if (srst_active) begin
      board_fail_bit <= 1'b0;
    end else if (wr_ok && aw_addr == ADDR_BUS_STATUS && lane0) begin
      board_fail_bit <= w_data[BIT_BOARD_FAIL_BIT];
    end
  end

  // Configuration space enable and base reloaded on each system reset.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cfg_en   <= 1'b0;
      cfg_base <= 5'h00;
    end else if (srst_active) begin
      if (mode == VPC_CFG_GEO) begin
        cfg_en   <= 1'b1;
        cfg_base <= ~ga_latched;
      end else begin
        cfg_en   <= 1'b0;
        cfg_base <= 5'h00;
      end
    end else if (wr_ok && aw_addr == ADDR_CFG_ATTRIBUTE && lane0) begin
      cfg_en <= w_data[BIT_CFG_EN];
    end else if (wr_ok && aw_addr == ADDR_CFG_BASE && lane0) begin
      cfg_base <= w_data[BASE_MSB:BASE_LSB];
    end
  end

  // Registered outputs.
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SYSTEM_FAIL_O     <= 1'b0;
      SYSCON_FUNCTION_O <= 1'b0;
      CFG_SPACE_EN_O    <= 1'b0;
      CFG_BASE_O        <= 5'h00;
    end else begin
      SYSTEM_FAIL_O     <= hold || (sfen && (!BOARD_FAIL_N_I || board_fail_bit));
      SYSCON_FUNCTION_O <= syscon;
      CFG_SPACE_EN_O    <= cfg_en;
      CFG_BASE_O        <= cfg_base;
    end
  end

  // ==========================================================================
  // Assertions.
  property p_fail_hold;
    @(posedge CLK_I) disable iff (!RST_N_I) hold |=> SYSTEM_FAIL_O;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail output low while hold set");

  property p_auto_set;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (srst_active && mode == VPC_CFG_AUTO) |=> hold;
  endproperty
  a_auto_set: assert property (p_auto_set) else $error("hold not set by reset");

  property p_geo_load;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (srst_active && mode == VPC_CFG_GEO) |=> (cfg_en && cfg_base == ~$past(ga_latched));
  endproperty
  a_geo_load: assert property (p_geo_load) else $error("geo base not loaded");

  property p_off_load;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (srst_active && mode != VPC_CFG_GEO) |=> (!cfg_en && cfg_base == 5'h00);
  endproperty
  a_off_load: assert property (p_off_load) else $error("config space not cleared");

  property p_opt_stable;
    @(posedge CLK_I) disable iff (!RST_N_I) !pur_rise |=> $stable(opt);
  endproperty
  a_opt_stable: assert property (p_opt_stable) else $error("options changed");

  property p_opt_capture;
    @(posedge CLK_I) disable iff (!RST_N_I) pur_rise |=> opt == $past(OPTION_DATA_I);
  endproperty
  a_opt_capture: assert property (p_opt_capture) else $error("options not captured");

  property p_sfen_rv;
    @(posedge CLK_I) disable iff (!RST_N_I) srst_active |=> sfen == $past(opt[OPT_SFEN_RV]);
  endproperty
  a_sfen_rv: assert property (p_sfen_rv) else $error("enable reset value wrong");

  property p_board_fail;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (sfen && !BOARD_FAIL_N_I) |=> SYSTEM_FAIL_O;
  endproperty
  a_board_fail: assert property (p_board_fail) else $error("board fail not forwarded");

  property p_syscon_on;
    @(posedge CLK_I) disable iff (!RST_N_I)
      (pur_rise && !SYSCON_FORCE_ON_N_I && SYSCON_FORCE_OFF_N_I) |=> ##1 SYSCON_FUNCTION_O;
  endproperty
  a_syscon_on: assert property (p_syscon_on) else $error("syscon not enabled");

  c_auto_clear: cover property (@(posedge CLK_I) disable iff (!RST_N_I) $fell(hold) && !srst_active);
  c_geo_mode:   cover property (@(posedge CLK_I) disable iff (!RST_N_I) cfg_en);
  c_syscon:     cover property (@(posedge CLK_I) disable iff (!RST_N_I) SYSCON_FUNCTION_O);

endmodule
`default_nettype wire

/* shared/vpc_pkg.sv */
// Package with register map, field positions and timing constants for the power-up option loader.
package vpc_pkg;
  // ==========================================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_BUS_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_CTRL_STATUS   = 8'h04;
  localparam logic [7:0] ADDR_BUS_STATUS    = 8'h08;
  localparam logic [7:0] ADDR_BIT_CLEAR     = 8'h0C;
  localparam logic [7:0] ADDR_BIT_SET       = 8'h10;
  localparam logic [7:0] ADDR_CFG_ATTRIBUTE = 8'h14;
  localparam logic [7:0] ADDR_CFG_BASE      = 8'h18;
  localparam logic [7:0] ADDR_OPTIONS       = 8'h1C;
  localparam logic [7:0] ADDR_MASK          = 8'hFC;
  // ==========================================================================
  // Field positions.
  localparam int BIT_HOLD       = 0;
  localparam int BIT_SFEN       = 0;
  localparam int BIT_BOARD_FAIL_BIT      = 0;
  localparam int BIT_SYSCON     = 1;
  localparam int BIT_SFO        = 2;
  localparam int BIT_CLRSET     = 6;
  localparam int BIT_CFG_EN     = 0;
  localparam int BASE_LSB       = 3;
  localparam int BASE_MSB       = 7;
  localparam int OPT_SFEN_RV    = 0;
  localparam int OPT_AUTOCLR    = 1;
  localparam int OPT_AUTO_SLOT  = 2;
  localparam int OPT_GEO_SLOT   = 3;
  // ==========================================================================
  // Responses and timing.
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [4:0]  GA_ALL_HIGH = 5'h1F;
  localparam int          CLK_MHZ     = 200;
  localparam int          AUTOCLR_MS  = 1;
  localparam int          AUTOCLR_CYC = AUTOCLR_MS * 1000 * CLK_MHZ;
  localparam int          CNT_W       = 18;
  // Addressing mode chosen from latched options.
  typedef enum logic [1:0] {
    VPC_CFG_OFF,
    VPC_CFG_GEO,
    VPC_CFG_AUTO
  } vpc_mode_t;
endpackage

/* sim/vpc_backplane.sv */
// Behavioural model of the strap resistors, data lines and board fail logic.
`timescale 1ns/1ps
`default_nettype none

module vpc_backplane (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Requests from the bench.
  input  wire logic       powerup_n_i,
  input  wire logic [3:0] strap_i,
  input  wire logic       fail_req_i,
  // Lines seen by the block.
  output logic      [3:0] data_o,
  output logic            board_fail_n_o
);
  logic [1:0] pu_hist;

  // ==========================================================================
  // Strap resistors
  // Straps show while the transceivers are off and two cycles after; the
  // lines then carry live bus traffic, modelled as a value that flips.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pu_hist <= 2'h0;
      data_o  <= 4'h0;
    end else begin
      pu_hist <= {pu_hist[0], powerup_n_i};
      if (!pu_hist[1]) begin
        data_o <= strap_i;
      end else begin
        data_o <= ~data_o;
      end
    end
  end

  // External board logic drives the active-low fail line.
  assign board_fail_n_o = ~fail_req_i;
endmodule
`default_nettype wire

/* sim/vpc_loader_bench.sv */
// Self-checking bench for the power-up option loader.
`timescale 1ns/1ps
`default_nettype none

module vpc_loader_bench;
  import vpc_pkg::*;
  localparam int ACL = 20;
  logic        clk, rst_n, pu_n, srst_n, g3_n, son_n, soff_n, fail_req, board_n;
  logic        fail, sys, cen;
  logic [3:0]  strap, opt_data, wstrb;
  logic [4:0]  ga_n, base;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          error_cnt, num_checks;

  // ==========================================================================
  // Design, far side and clock
  vpc_loader #(.AUTOCLR_CYCLES(ACL)) uut (
    .CLK_I(clk), .RST_N_I(rst_n), .POWERUP_RESET_N_I(pu_n), .SYSTEM_RESET_N_I(srst_n),
    .OPTION_DATA_I(opt_data), .GEO_ADDR_N_I(ga_n), .GRANT3_DAISY_N_I(g3_n),
    .SYSCON_FORCE_ON_N_I(son_n), .SYSCON_FORCE_OFF_N_I(soff_n), .BOARD_FAIL_N_I(board_n),
    .SYSTEM_FAIL_O(fail), .SYSCON_FUNCTION_O(sys), .CFG_SPACE_EN_O(cen), .CFG_BASE_O(base),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  vpc_backplane bp (.clk_i(clk), .rst_n_i(rst_n), .powerup_n_i(pu_n), .strap_i(strap),
    .fail_req_i(fail_req), .data_o(opt_data), .board_fail_n_o(board_n));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Compares one result and counts it.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // Waits whole cycles and samples just after the edge.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Compares the four derived outputs as {fail, syscon, enable, base}.
  task automatic outs(input logic [7:0] e);
    settle(3);
    chk("outputs", {24'h0, e}, {24'h0, fail, sys, cen, base});
  endtask
  // One write; each channel is released at the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    {awaddr, wdata, wstrb} <= {a, d, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        chk("write response", {30'h0, er}, {30'h0, bresp});
        bready <= 1'b0;
        break;
      end
    end
    if (n >= 100) begin
      error_cnt++;
      test_done();
    end
  endtask
  // One read with data and response compared.
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        chk("read data", ed, rdata);
        chk("read response", {30'h0, er}, {30'h0, rresp});
        rready <= 1'b0;
        break;
      end
    end
    if (n >= 100) begin
      error_cnt++;
      test_done();
    end
  endtask
  // Power-up reset with straps; straps other than data move after release.
  task automatic pwr(input logic [3:0] o, input logic [4:0] g, input logic on_n,
                     input logic off_n, input logic g3);
    @(posedge clk);
    {pu_n, strap, ga_n, son_n, soff_n, g3_n} <= {1'b0, o, g, on_n, off_n, g3};
    repeat (4) @(posedge clk);
    pu_n <= 1'b1;
    repeat (2) @(posedge clk);
    {ga_n, son_n, soff_n} <= {~g, ~on_n, ~off_n};
  endtask
  // Pulses the system reset input.
  task automatic sys_reset();
    @(posedge clk);
    srst_n <= 1'b0;
    repeat (3) @(posedge clk);
    srst_n <= 1'b1;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {clk, rst_n, pu_n, srst_n, g3_n, son_n, soff_n, fail_req} = 8'h1E;
    {strap, ga_n, awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    error_cnt = 0;
    num_checks = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    pwr(4'b1000, 5'h15, 1'b0, 1'b1, 1'b1);
    outs({1'b0, 1'b1, 1'b1, 5'h0A});
    sys_reset();
    outs({1'b0, 1'b1, 1'b1, 5'h0A});
    pwr(4'b0000, 5'h15, 1'b1, 1'b0, 1'b1);
    outs(8'h00);
    pwr(4'b0100, 5'h00, 1'b1, 1'b1, 1'b0);
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    rd(ADDR_BUS_CONTROL, 32'h1, RESP_OKAY);
    settle(2 * ACL);
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    wr(ADDR_BUS_CONTROL, 32'h0, RESP_OKAY);
    outs({1'b0, 1'b1, 1'b0, 5'h00});
    sys_reset();
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    pwr(4'b0110, 5'h00, 1'b1, 1'b1, 1'b1);
    outs({1'b1, 1'b0, 1'b0, 5'h00});
    settle(ACL + 10);
    outs(8'h00);
    pwr(4'b1100, 5'h1F, 1'b0, 1'b1, 1'b1);
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    pwr(4'b1100, 5'h1E, 1'b0, 1'b1, 1'b1);
    outs({1'b0, 1'b1, 1'b1, 5'h01});
    pwr(4'b0001, 5'h00, 1'b0, 1'b1, 1'b1);
    outs({1'b0, 1'b1, 1'b0, 5'h00});
    rd(ADDR_CTRL_STATUS, 32'h1, RESP_OKAY);
    fail_req <= 1'b1;
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    wr(ADDR_BIT_CLEAR, 32'h40, RESP_OKAY);
    outs({1'b0, 1'b1, 1'b0, 5'h00});
    rd(ADDR_BIT_SET, 32'h0, RESP_OKAY);
    wr(ADDR_BIT_SET, 32'h40, RESP_OKAY);
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    fail_req <= 1'b0;
    outs({1'b0, 1'b1, 1'b0, 5'h00});
    wr(ADDR_BUS_STATUS, 32'h1, RESP_OKAY);
    outs({1'b1, 1'b1, 1'b0, 5'h00});
    rd(ADDR_BUS_STATUS, 32'h7, RESP_OKAY);
    wr(ADDR_CTRL_STATUS, 32'h0, RESP_OKAY);
    outs({1'b0, 1'b1, 1'b0, 5'h00});
    rd(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h21, 32'h1, RESP_SLVERR);
    test_done();
  end
endmodule
`default_nettype wire
